// *** common/dtmf_defines.svh ***
// Offsets, field positions, reset values and timing figures of the tone block.
// Assumes a 1-bit register select and a 4-bit data path from the host.
`ifndef DTMF_DEFINES_SVH
`define DTMF_DEFINES_SVH

// Register selects
`define DTMF_ADDR_DATA 1'b0
`define DTMF_ADDR_CTRL 1'b1

// Control register A fields
`define DTMF_CRA_TONE 0
`define DTMF_CRA_CP 1
`define DTMF_CRA_IRQ 2
`define DTMF_CRA_RSEL 3

// Control register B fields
`define DTMF_CRB_BURST_OFF 0
`define DTMF_CRB_TEST 1
`define DTMF_CRB_SINGLE 2
`define DTMF_CRB_HIGH_GROUP 3

// Status register fields
`define DTMF_ST_IRQ 0
`define DTMF_ST_TX_EMPTY 1
`define DTMF_ST_RX_FULL 2
`define DTMF_ST_STEER_N 3

// Reset values
`define DTMF_CRA_RST 4'h0
`define DTMF_CRB_RST 4'h0
`define DTMF_TX_EMPTY_RST 1'b1

// Timing: reference rate, burst length, segments per tone period
`define DTMF_REF_HZ 3579545
`define DTMF_BURST_MS 51
`define DTMF_SEGMENTS 32

// Segment lengths in reference ticks, low group then high group
`define DTMF_SEG_697 8'hA0
`define DTMF_SEG_770 8'h92
`define DTMF_SEG_852 8'h84
`define DTMF_SEG_941 8'h76
`define DTMF_SEG_1209 8'h5C
`define DTMF_SEG_1336 8'h54
`define DTMF_SEG_1477 8'h4C
`define DTMF_SEG_1633 8'h44

`endif

// *** common/dtmf_pkg.sv ***
// Types shared by the tone block.
// Assumes nothing beyond a SystemVerilog compiler.
package dtmf_pkg;
    typedef enum logic [1:0] {BURST_IDLE, BURST_TONE, BURST_PAUSE} burst_state_e;
endpackage : dtmf_pkg

// *** hdl/dtmf_tone_gen_burst_timer.sv ***
// Digital control of a dual-tone transceiver: host registers, receive
// latching, call-progress pin, tone dividers and burst timer.
// Assumes the analog detector, steering RC and D/A sit outside; their
// levels arrive on pins and are synchronised here.
`include "dtmf_defines.svh"

module dtmf_tone_gen_burst_timer
    import dtmf_pkg::*;
#(
    parameter int BURST_TICKS = `DTMF_BURST_MS * `DTMF_REF_HZ / 1000,
    parameter int CW = 20
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Host register port
    input wire logic regAddr,
    input wire logic [3:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [3:0] rdData,
    // Reference and receiver pins
    input wire logic refClockPin,
    input wire logic early_steering_out,
    input wire logic steeringIn,
    input wire logic [3:0] decodedDigit,
    input wire logic cpSquareIn,
    output logic steering_in_guard_out,
    // Shared open-drain pin, active low
    output logic interrupt_or_tone_pin_out,
    output logic interrupt_or_tone_pin_oe,
    // Tone generators
    output logic [4:0] rowTableAddr,
    output logic [4:0] colTableAddr,
    output logic rowActive,
    output logic colActive,
    output logic [7:0] toneSelect
);

    generate
        if (BURST_TICKS < 1 || 2 * BURST_TICKS >= 2 ** CW) begin : g_bad_param
            $error("BURST_TICKS does not fit the burst counter");
        end
    endgenerate

    // Code to {row, column}, each a group index 0..3
    function automatic logic [3:0] digitToPair(input logic [3:0] code);
        case (code)
            4'h1: digitToPair = 4'h0;
            4'h2: digitToPair = 4'h1;
            4'h3: digitToPair = 4'h2;
            4'h4: digitToPair = 4'h4;
            4'h5: digitToPair = 4'h5;
            4'h6: digitToPair = 4'h6;
            4'h7: digitToPair = 4'h8;
            4'h8: digitToPair = 4'h9;
            4'h9: digitToPair = 4'hA;
            4'hA: digitToPair = 4'hD;
            4'hB: digitToPair = 4'hC;
            4'hC: digitToPair = 4'hE;
            4'hD: digitToPair = 4'h3;
            4'hE: digitToPair = 4'h7;
            4'hF: digitToPair = 4'hB;
            default: digitToPair = 4'hF;
        endcase
    endfunction : digitToPair

    // Segment length for one hot group selection
    function automatic logic [7:0] segLength(input logic [3:0] oneHot, input logic high);
        logic [7:0] len;
        len = high ? `DTMF_SEG_1633 : `DTMF_SEG_941;
        if (oneHot[0]) begin
            len = high ? `DTMF_SEG_1209 : `DTMF_SEG_697;
        end else if (oneHot[1]) begin
            len = high ? `DTMF_SEG_1336 : `DTMF_SEG_770;
        end else if (oneHot[2]) begin
            len = high ? `DTMF_SEG_1477 : `DTMF_SEG_852;
        end
        segLength = len;
    endfunction : segLength

    // Pin synchroniser: three stages, filtered once stages 2 and 3 agree
    localparam int NPIN = 8;
    logic [NPIN-1:0] pinS1;
    logic [NPIN-1:0] pinS2;
    logic [NPIN-1:0] pinS3;
    logic [NPIN-1:0] pinF;
    wire [NPIN-1:0] pinRaw = {decodedDigit, cpSquareIn, steeringIn,
                              early_steering_out, refClockPin};
    wire [NPIN-1:0] pinAgree = ~(pinS2 ^ pinS3);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pinS1 <= '0;
            pinS2 <= '0;
            pinS3 <= '0;
            pinF <= '0;
        end else begin
            pinS1 <= pinRaw;
            pinS2 <= pinS1;
            pinS3 <= pinS2;
            pinF <= (pinAgree & pinS3) | (~pinAgree & pinF);
        end
    end
    wire refF = pinF[0];
    wire earlyF = pinF[1];
    wire steerF = pinF[2];
    wire cpF = pinF[3];
    wire [3:0] codeF = pinF[7:4];

    // Host registers
    logic [3:0] ctrlA;
    logic [3:0] ctrlB;
    logic [3:0] rxData;
    logic [3:0] txCode;
    logic irqFlag;
    logic txEmpty;
    logic rxFull;
    logic steerPrev;
    logic refPrev;
    wire toneEnable = ctrlA[`DTMF_CRA_TONE];
    wire cpMode = ctrlA[`DTMF_CRA_CP];
    wire irqEnable = ctrlA[`DTMF_CRA_IRQ];
    wire burstMode = ~ctrlB[`DTMF_CRB_BURST_OFF];
    wire singleTone = ctrlB[`DTMF_CRB_SINGLE];
    wire highGroup = ctrlB[`DTMF_CRB_HIGH_GROUP];

    // Bus decode
    wire ctrlWrite = wrStrobe && regAddr == `DTMF_ADDR_CTRL;
    wire txWrite = wrStrobe && regAddr == `DTMF_ADDR_DATA;
    wire stRead = rdStrobe && regAddr == `DTMF_ADDR_CTRL;
    wire [3:0] statusWord = {~steerF, rxFull, txEmpty, irqFlag};
    wire [3:0] next_rdData = !rdStrobe ? 4'h0 : (regAddr ? statusWord : rxData);

    // Steering edge latches only outside call progress mode
    wire rxLatch = steerF && !steerPrev && !cpMode;
    wire refTick = refF && !refPrev;

    // Control writes: bit 3 of A steers the next control write to B
    logic toB;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrlA <= `DTMF_CRA_RST;
            ctrlB <= `DTMF_CRB_RST;
            toB <= 1'b0;
        end else if (ctrlWrite) begin
            if (toB) begin
                ctrlB <= wrData;
                toB <= 1'b0;
            end else begin
                ctrlA <= wrData;
                toB <= wrData[`DTMF_CRA_RSEL];
            end
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= 4'h0;
        end else begin
            rdData <= next_rdData;
        end
    end

    // Receive data changes only on a steering rise, so short tones and
    // dropouts filtered by the external RC never reach it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rxData <= 4'h0;
            steerPrev <= 1'b0;
            refPrev <= 1'b0;
        end else begin
            steerPrev <= steerF;
            refPrev <= refF;
            if (rxLatch) begin
                rxData <= codeF;
            end
        end
    end

    // Guard output drives the RC once a digit registers, while tone stays
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            steering_in_guard_out <= 1'b0;
        end else begin
            steering_in_guard_out <= earlyF && (rxLatch || steering_in_guard_out);
        end
    end

    // Burst timer
    burst_state_e bState;
    logic [CW-1:0] bCount;
    localparam logic [CW-1:0] LAST_STD = CW'(BURST_TICKS - 1);
    localparam logic [CW-1:0] LAST_CP = CW'(2 * BURST_TICKS - 1);
    wire [CW-1:0] bLast = cpMode ? LAST_CP : LAST_STD;
    wire bEnd = refTick && bCount == bLast;
    wire burstDone = bState == BURST_PAUSE && bEnd;

    // Sticky flags: a set in the same cycle as a read wins
    wire flagEvent = rxLatch || (burstDone && !cpMode);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irqFlag <= 1'b0;
            rxFull <= 1'b0;
            txEmpty <= `DTMF_TX_EMPTY_RST;
        end else begin
            irqFlag <= (flagEvent && irqEnable) || (irqFlag && !stRead);
            rxFull <= rxLatch || (rxFull && !stRead);
            txEmpty <= burstDone || (txEmpty && !(txWrite && burstMode));
        end
    end

    // Shared pin, only with the IRQ bit set: square wave in call progress, else interrupt pull-down
    logic next_pinOe;
    always_comb begin
        next_pinOe = 1'b0;
        if (cpMode && irqEnable) begin
            next_pinOe = !cpF;
        end else if (irqEnable) begin
            next_pinOe = irqFlag;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            interrupt_or_tone_pin_oe <= 1'b0;
            interrupt_or_tone_pin_out <= 1'b0;
        end else begin
            interrupt_or_tone_pin_oe <= next_pinOe;
            interrupt_or_tone_pin_out <= 1'b0;
        end
    end

    // Burst sequencing: a write restarts the burst at its first tick
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bState <= BURST_IDLE;
            bCount <= '0;
        end else if (txWrite && burstMode) begin
            bState <= BURST_TONE;
            bCount <= '0;
        end else begin
            case (bState)
                BURST_TONE, BURST_PAUSE: begin
                    if (!burstMode) begin
                        bState <= BURST_IDLE;
                    end else if (bEnd) begin
                        bCount <= '0;
                        bState <= bState == BURST_TONE ? BURST_PAUSE : BURST_IDLE;
                    end else if (refTick) begin
                        bCount <= bCount + 1'b1;
                    end
                end
                default: begin
                    bCount <= '0;
                end
            endcase
        end
    end

    // Transmit code latch and its two of eight selection
    wire [3:0] pair = digitToPair(txCode);
    wire [7:0] next_select = {4'(1) << pair[1:0], 4'(1) << pair[3:2]};
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            txCode <= 4'h0;
            toneSelect <= 8'h88;
        end else begin
            if (txWrite) begin
                txCode <= wrData;
            end
            toneSelect <= next_select;
        end
    end

    // Tone gating: burst window or enable bit alone
    wire toneOn = toneEnable && (!burstMode || bState == BURST_TONE);
    wire rowOn = toneOn && !(singleTone && highGroup);
    wire colOn = toneOn && !(singleTone && !highGroup);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rowActive <= 1'b0;
            colActive <= 1'b0;
        end else begin
            rowActive <= rowOn;
            colActive <= colOn;
        end
    end

    // Segment dividers; an idle generator parks at address 0 so the next
    // burst starts at phase zero
    logic [7:0] rowSeg;
    logic [7:0] colSeg;
    wire [7:0] rowLen = segLength(toneSelect[3:0], 1'b0);
    wire [7:0] colLen = segLength(toneSelect[7:4], 1'b1);
    wire rowStep = refTick && rowSeg >= rowLen - 8'h01;
    wire colStep = refTick && colSeg >= colLen - 8'h01;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rowSeg <= 8'h00;
            colSeg <= 8'h00;
            rowTableAddr <= 5'h00;
            colTableAddr <= 5'h00;
        end else begin
            if (!rowOn) begin
                rowSeg <= 8'h00;
                rowTableAddr <= 5'h00;
            end else if (rowStep) begin
                rowSeg <= 8'h00;
                rowTableAddr <= rowTableAddr + 5'h01;
            end else if (refTick) begin
                rowSeg <= rowSeg + 8'h01;
            end
            if (!colOn) begin
                colSeg <= 8'h00;
                colTableAddr <= 5'h00;
            end else if (colStep) begin
                colSeg <= 8'h00;
                colTableAddr <= colTableAddr + 5'h01;
            end else if (refTick) begin
                colSeg <= colSeg + 8'h01;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    cp_blocks_rx_a: assert property (cpMode |=> $stable(rxData) && !$rose(rxFull))
        else $error("digit latched in call progress mode");
    cp_pin_wave_a: assert property (
        cpMode && irqEnable |=> interrupt_or_tone_pin_oe == !$past(cpF))
        else $error("call progress pin does not follow square wave");
    rx_hold_a: assert property (!rxLatch |=> $stable(rxData))
        else $error("receive data changed without a valid tone");
    rx_latch_a: assert property (rxLatch |=> rxData == $past(codeF) && rxFull)
        else $error("valid tone not latched");
    status_clear_a: assert property (stRead && !rxLatch |=> !rxFull)
        else $error("receive flag survived status read");
    irq_raise_a: assert property (
        rxLatch && irqEnable && !cpMode |=> ##1 interrupt_or_tone_pin_oe)
        else $error("interrupt not raised on new data");
    burst_phase_a: assert property (
        bState == BURST_TONE && bEnd && !txWrite && burstMode |=> bState == BURST_PAUSE)
        else $error("burst did not move to pause");
    ready_set_a: assert property (burstDone |=> txEmpty)
        else $error("transmit ready not set after pause");
    table_wrap_a: assert property (
        rowOn && rowStep && rowTableAddr == 5'h1F |=> rowTableAddr == 5'h00)
        else $error("row table address did not wrap");
    single_tone_a: assert property (singleTone |=> !(rowActive && colActive))
        else $error("both tones active in single tone mode");

    cov_rx_digit: cover property (rxLatch ##[1:20] stRead);
    cov_burst_done: cover property (burstDone);
    cov_cp_wave: cover property (cpMode && irqEnable && $rose(cpF));

endmodule : dtmf_tone_gen_burst_timer

// *** tb/rx_front_model.sv ***
// Behavioural front end of the receiver: free-running reference crystal,
// tone detector and steering RC network.
// Assumes the bench starts and stops tones; the RC sets the guard time.
module rx_front_model #(
    parameter int GUARD = 30
) (
    // Line conditions set by the bench
    input logic tonePresent,
    input logic [3:0] toneCode,
    input logic cpLevel,
    // Reference and detector pins
    output logic refClockPin,
    output logic early_steering_out,
    output logic steeringIn,
    output logic [3:0] decodedDigit,
    output logic cpSquareIn
);
    timeunit 1ns;
    timeprecision 1ps;

    int rc;

    // Detector follows the line at once; once the pair is lost the decoder
    // lines drift, so a late sample of them would show a wrong code
    assign early_steering_out = tonePresent;
    assign decodedDigit = tonePresent ? toneCode : ~toneCode;
    assign cpSquareIn = cpLevel;

    // Crystal runs continuously, 3.579545 MHz
    initial begin
        refClockPin = 1'b0;
        steeringIn = 1'b0;
        rc = 0;
        forever #139.682 refClockPin = ~refClockPin;
    end

    // RC guard: steering follows the detector only after GUARD steady ticks
    always @(posedge refClockPin) begin
        if (early_steering_out == steeringIn) begin
            rc <= 0;
        end else if (rc == GUARD - 1) begin
            steeringIn <= early_steering_out;
            rc <= 0;
        end else begin
            rc <= rc + 1;
        end
    end
endmodule : rx_front_model

// *** tb/dtmf_tone_gen_burst_timer_tb.sv ***
// Self-checking bench of the tone block: register tasks, tone selection,
// burst timing, receive latching and the shared pin.
// Assumes the front-end model drives the async receiver pins.
`include "dtmf_defines.svh"

module dtmf_tone_gen_burst_timer_tb
    import dtmf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BT = 20;
    localparam int GUARD = 30;

    logic clock, arst_n, regAddr, wrStrobe, rdStrobe;
    logic [3:0] wrData, rdData, decodedDigit;
    logic refClockPin, early_steering_out, steeringIn, cpSquareIn;
    logic tonePresent, cpLevel;
    logic [3:0] toneCode;
    logic steering_in_guard_out, pinOut, pinOe, rowActive, colActive;
    logic [4:0] rowTableAddr, colTableAddr;
    logic [7:0] toneSelect;
    logic [3:0] s;
    logic [4:0] prev;
    int bad_count = 0;
    int check_count = 0;
    int n;

    dtmf_tone_gen_burst_timer #(.BURST_TICKS(BT)) i_dtmf_tone_gen_burst_timer (
        .clock(clock), .arst_n(arst_n), .regAddr(regAddr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
        .refClockPin(refClockPin), .early_steering_out(early_steering_out),
        .steeringIn(steeringIn), .decodedDigit(decodedDigit), .cpSquareIn(cpSquareIn),
        .steering_in_guard_out(steering_in_guard_out),
        .interrupt_or_tone_pin_out(pinOut), .interrupt_or_tone_pin_oe(pinOe),
        .rowTableAddr(rowTableAddr), .colTableAddr(colTableAddr),
        .rowActive(rowActive), .colActive(colActive), .toneSelect(toneSelect));

    rx_front_model #(.GUARD(GUARD)) i_rx_front_model (
        .tonePresent(tonePresent), .toneCode(toneCode), .cpLevel(cpLevel),
        .refClockPin(refClockPin), .early_steering_out(early_steering_out),
        .steeringIn(steeringIn), .decodedDigit(decodedDigit), .cpSquareIn(cpSquareIn));

    // 100 MHz system clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Counts compared with a tolerance, since the reference is asynchronous
    task automatic near(input int got, input int exp, input int tol);
        check_count++;
        if (got < exp - tol || got > exp + tol) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : near

    // One-cycle strobes launched just after a rising edge
    task automatic wr(input logic a, input logic [3:0] d);
        @(posedge clock);
        regAddr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clock);
        wrStrobe <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic a, output logic [3:0] d);
        @(posedge clock);
        regAddr <= a;
        rdStrobe <= 1'b1;
        @(posedge clock);
        rdStrobe <= 1'b0;
        #1 d = rdData;
    endtask : rd

    // Control B is reached through the select bit of control A; a carries
    // the other bits of A, which that first write would otherwise clear
    task automatic control_reg_b(input logic [3:0] a, input logic [3:0] v);
        wr(1'b1, a | 4'h8);
        wr(1'b1, v);
    endtask : control_reg_b

    // Line events for the front-end model, launched just after a rising edge
    task automatic toneStart(input logic [3:0] d);
        @(posedge clock);
        toneCode <= d;
        tonePresent <= 1'b1;
    endtask : toneStart

    task automatic toneStop();
        @(posedge clock);
        tonePresent <= 1'b0;
    endtask : toneStop

    task automatic cpDrive(input logic v);
        @(posedge clock);
        cpLevel <= v;
    endtask : cpDrive

    task automatic ticks(input int k);
        repeat (k) @(posedge refClockPin);
    endtask : ticks

    // Length of one row-tone burst in reference ticks
    task automatic measure(output int t);
        for (int i = 0; i < 20 && rowActive !== 1'b1; i++) @(posedge clock);
        t = 0;
        while (rowActive === 1'b1 && t < 1000) begin
            @(posedge refClockPin);
            t++;
        end
    endtask : measure

    // Expected two-of-eight selection for a digit code
    function automatic logic [7:0] sel(input logic [3:0] c);
        int r;
        int k;
        case (c)
            4'h1, 4'h2, 4'h3, 4'hD: r = 0;
            4'h4, 4'h5, 4'h6, 4'hE: r = 1;
            4'h7, 4'h8, 4'h9, 4'hF: r = 2;
            default: r = 3;
        endcase
        case (c)
            4'h1, 4'h4, 4'h7, 4'hB: k = 0;
            4'h2, 4'h5, 4'h8, 4'hA: k = 1;
            4'h3, 4'h6, 4'h9, 4'hC: k = 2;
            default: k = 3;
        endcase
        return 8'(1 << (k + 4)) | 8'(1 << r);
    endfunction : sel

    // Watchdog at over twice the expected run of about 200 us
    initial begin
        #500us;
        bad_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        regAddr = 1'b0;
        wrData = 4'h0;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        tonePresent = 1'b0;
        toneCode = 4'h0;
        cpLevel = 1'b0;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        repeat (5) @(posedge clock);
        rd(1'b1, s);
        chk(s, 8'h0A);
        chk(toneSelect, 8'h88);
        $display("reset test done");
        control_reg_b(4'h0, 4'h1);
        wr(1'b1, 4'h1);
        for (int c = 0; c < 16; c++) begin
            wr(1'b0, 4'(c));
            repeat (3) @(posedge clock);
            chk(toneSelect, sel(4'(c)));
            chk({rowActive, colActive}, 8'h03);
        end
        $display("code table test done");
        // Code F uses the 1633 Hz column; one segment per step, no gaps
        prev = colTableAddr;
        for (int i = 0; i < 4; i++) begin
            n = 0;
            while (colTableAddr === prev && n < 200) begin
                @(posedge refClockPin);
                n++;
            end
            if (i > 0) near(n, `DTMF_SEG_1633, 1);
            if (i > 0) chk(colTableAddr, 5'(prev + 5'h01));
            prev = colTableAddr;
        end
        $display("divider test done");
        wr(1'b1, 4'h0);
        repeat (3) @(posedge clock);
        chk({rowActive, colActive, rowTableAddr}, 8'h00);
        wr(1'b1, 4'h1);
        wr(1'b0, 4'h5);
        control_reg_b(4'h1, 4'h5);
        repeat (3) @(posedge clock);
        chk({rowActive, colActive}, 8'h02);
        control_reg_b(4'h1, 4'hD);
        repeat (3) @(posedge clock);
        chk({rowActive, colActive}, 8'h01);
        $display("enable and single tone test done");
        control_reg_b(4'h1, 4'h0);
        wr(1'b0, 4'h5);
        rd(1'b1, s);
        chk(s & 4'h2, 8'h00);
        measure(n);
        near(n, BT, 2);
        ticks(5);
        rd(1'b1, s);
        chk(s & 4'h2, 8'h00);
        ticks(BT);
        rd(1'b1, s);
        chk(s & 4'h2, 8'h02);
        wr(1'b1, 4'h3);
        wr(1'b0, 4'h9);
        measure(n);
        near(n, 2 * BT, 3);
        ticks(2 * BT + 10);
        $display("burst test done");
        wr(1'b1, 4'h5);
        rd(1'b1, s);
        toneStart(4'h5);
        ticks(GUARD + 10);
        rd(1'b0, s);
        chk(s, 8'h05);
        chk(pinOe, 8'h01);
        chk(pinOut, 8'h00);
        chk(steering_in_guard_out, 8'h01);
        rd(1'b1, s);
        chk(s & 4'hC, 8'h04);
        repeat (3) @(posedge clock);
        chk(pinOe, 8'h00);
        rd(1'b1, s);
        chk(s & 4'h4, 8'h00);
        toneStop();
        ticks(GUARD / 2);
        toneStart(4'h5);
        ticks(GUARD + 5);
        rd(1'b1, s);
        chk(s & 4'hC, 8'h00);
        toneStop();
        ticks(GUARD + 10);
        rd(1'b1, s);
        chk(s & 4'h8, 8'h08);
        toneStart(4'h3);
        ticks(GUARD / 2);
        toneStop();
        ticks(GUARD + 10);
        rd(1'b0, s);
        chk(s, 8'h05);
        $display("receive test done");
        wr(1'b1, 4'h6);
        toneStart(4'h3);
        ticks(GUARD + 10);
        rd(1'b0, s);
        chk(s, 8'h05);
        toneStop();
        cpDrive(1'b1);
        repeat (10) @(posedge clock);
        chk(pinOe, 8'h00);
        cpDrive(1'b0);
        repeat (10) @(posedge clock);
        chk(pinOe, 8'h01);
        wr(1'b1, 4'h2);
        repeat (10) @(posedge clock);
        chk(pinOe, 8'h00);
        $display("call progress test done");
        stop_test();
    end
endmodule : dtmf_tone_gen_burst_timer_tb
